// ===== rtl/mcr_pkg.sv
// Shared constants, types and lookups for the monitor configuration register bank
package mcr_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_POWER = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_PART = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_REV = 8'h06;
    localparam logic [ADDR_W-1:0] ADDR_MAKER = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_CFGA = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_CFGB = 8'h11;

    // Reset values
    localparam logic [DATA_W-1:0] RST_POWER = 16'h0000;
    localparam logic [DATA_W-1:0] RST_CFGA = 16'h0300;
    localparam logic [DATA_W-1:0] RST_CFGB = 16'h036A;

    // Field positions, power register
    localparam int PWR_MODE_LSB = 0;

    // Field positions, first configuration word
    localparam int CFGA_TRIG_BIT = 12;
    localparam int CFGA_CSAVG_LSB = 8;
    localparam int CFGA_RTAVG_LSB = 4;
    localparam int CFGA_LOOP_BIT = 0;

    // Field positions, second configuration word
    localparam int CFGB_PINON_BIT = 15;
    localparam int CFGB_PINFUNC_BIT = 14;
    localparam int CFGB_CHDEB_LSB = 8;
    localparam int CFGB_PNP_BIT = 7;
    localparam int CFGB_CUTOFF_BIT = 6;
    localparam int CFGB_LTDEB_LSB = 4;
    localparam int CFGB_RT2DEB_LSB = 2;
    localparam int CFGB_RT1DEB_LSB = 0;

    // Highest valid averaging codes
    localparam logic [2:0] CS_AVG_MAX = 3'h4;
    localparam logic [2:0] RT_AVG_MAX = 3'h5;

    // Timing: clock period and one millisecond, both in picoseconds
    localparam int CLK_PERIOD_PS = 4000;
    localparam int MS_PS = 1000000000;
    localparam int CYC_PER_MS = MS_PS / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        PWR_DOWN_A = 2'b00,
        PWR_DOWN_B = 2'b01,
        PWR_ACTIVE = 2'b10,
        PWR_RSVD = 2'b11
    } mcr_pwr_e;

    typedef enum logic [1:0] {
        AMP_OFF = 2'b00,
        AMP_ON = 2'b01,
        AMP_LOCKED = 2'b10
    } mcr_amp_e;

    // Remote sensor update period in ms; zero marks an invalid code
    function automatic logic [6:0] rt_update_ms(input logic [2:0] code);
        case (code)
            3'h0: return 7'h10;
            3'h1: return 7'h10;
            3'h2: return 7'h12;
            3'h3: return 7'h1A;
            3'h4: return 7'h32;
            3'h5: return 7'h62;
            default: return 7'h00;
        endcase
    endfunction

    // Channel debounce: 1, then 4 doubling up to 256
    function automatic logic [8:0] chan_debounce(input logic [2:0] code);
        if (code == 3'h0)
        begin
            return 9'h001;
        end
        return 9'h001 << ({1'b0, code} + 4'h1);
    endfunction

    // Temperature debounce: 1, 2, 4, 8
    function automatic logic [8:0] temp_debounce(input logic [1:0] code);
        return 9'h001 << code;
    endfunction

endpackage

// ===== rtl/mcr_debounce.sv
// Consecutive out-of-range sample counter that raises one alarm
`timescale 1ns/10ps
module mcr_debounce #(
    parameter int CntW = 9
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Samples
    input wire logic sampleStb,
    input wire logic outOfRange,
    input wire logic [CntW-1:0] target,
    // Result
    output logic alarm
);
    typedef struct packed {
        logic [CntW-1:0] cnt;
        logic alarm;
    } mcr_deb_s;

    mcr_deb_s q;
    mcr_deb_s d;

    always_comb
    begin
        d = q;
        if (sampleStb)
        begin
            if (!outOfRange)
            begin
                d.cnt = '0;
                d.alarm = 1'b0;
            end
            else if (q.cnt + 1'b1 >= target)
            begin
                // Saturate so a long excursion cannot wrap back to zero
                d.cnt = target;
                d.alarm = 1'b1;
            end
            else
            begin
                d.cnt = q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign alarm = q.alarm;
endmodule // mcr_debounce

// ===== rtl/mcr_cs_filter.sv
// First-order recursive averaging filter for current-sense samples
`timescale 1ns/10ps
module mcr_cs_filter #(
    parameter int SampleW = 12,
    parameter int FracW = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic enable,
    input wire logic [2:0] shift,
    // Samples in
    input wire logic sampleStb,
    input wire logic [SampleW-1:0] sample,
    // Filtered out
    output logic [SampleW-1:0] filtered,
    output logic filteredValid
);
    localparam int AccW = SampleW + FracW;

    typedef struct packed {
        logic [AccW-1:0] acc;
        logic valid;
    } mcr_flt_s;

    mcr_flt_s q;
    mcr_flt_s d;
    logic signed [AccW:0] diff;
    logic signed [AccW:0] step;
    logic signed [AccW:0] sum;

    // y += (x - y) / K; fraction bits keep small steps from vanishing
    always_comb
    begin
        diff = $signed({1'b0, sample, {FracW{1'b0}}}) - $signed({1'b0, q.acc});
        step = diff >>> shift;
        sum = $signed({1'b0, q.acc}) + step;
        d = q;
        d.valid = 1'b0;
        if (enable && sampleStb && shift <= 3'h4)
        begin
            d.acc = sum[AccW-1:0];
            d.valid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign filtered = q.acc[AccW-1:FracW];
    assign filteredValid = q.valid;
endmodule // mcr_cs_filter

// ===== rtl/mcr_regs.sv
// Power, identification and global configuration registers of the monitor
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
module mcr_regs
    import mcr_pkg::*;
#(
    parameter logic [DATA_W-1:0] PartCode = 16'h5A01,      // Arbitrary value
    parameter logic [DATA_W-1:0] RevisionCode = 16'h0A0A,  // Arbitrary value
    parameter logic [DATA_W-1:0] MakerCode = 16'h0E0E,     // Arbitrary value
    parameter int MsCycles = CYC_PER_MS,
    parameter int SampleW = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [mcr_pkg::ADDR_W-1:0] regAddr,
    input wire logic [mcr_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [mcr_pkg::DATA_W-1:0] regRdata,
    // Analog power enables
    output logic referenceOn,
    output logic currentSenseOn,
    output logic adcOn,
    output logic adcRefBufOn,
    output logic dacRefBufOn,
    output logic auxDacOn,
    output logic bipolarDacOn,
    output logic powerCodeInvalid,
    // Configuration to converters
    output logic conversionTriggerSel,
    output logic loopEnable,
    output logic [2:0] remoteTempAvgSel,
    output logic remoteDiodePnpSel,
    output logic csAvgInvalid,
    output logic rtAvgInvalid,
    output logic remoteTempTick,
    // Current-sense filter
    input wire logic csSampleStb,
    input wire logic [SampleW-1:0] csSample,
    output logic [SampleW-1:0] csFiltered,
    output logic csFilteredValid,
    // Alarm samples: 0 channel, 1 local, 2 remote 2, 3 remote 1
    input wire logic [3:0] alarmSampleStb,
    input wire logic [3:0] alarmOutOfRange,
    output logic [3:0] alarmFlags,
    // Amplifier enable
    input wire logic ampOnReq,
    input wire logic negSupplyAlarm,
    output logic ampEnablePin,
    // Result pin
    input wire logic dataValidIn,
    input wire logic adcReadyIn,
    output logic resultPinOut,
    output logic resultPinOe
);
    import mcr_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] power;
        logic [DATA_W-1:0] cfgA;
        logic [DATA_W-1:0] cfgB;
        logic [DATA_W-1:0] rdata;
        logic [31:0] rtCnt;
        logic rtTick;
        mcr_amp_e amp;
        logic pinOut;
        logic pinOe;
    } mcr_regs_s;

    mcr_regs_s q;
    mcr_regs_s d;

    mcr_pwr_e pwrMode;
    logic pwrActive;
    logic [2:0] csAvgCode;
    logic [2:0] rtAvgCode;
    logic cutoffOn;
    logic [31:0] rtPeriod;
    logic [8:0] debTarget [4];

    // Field decode
    assign pwrMode = mcr_pwr_e'(q.power[PWR_MODE_LSB +: 2]);
    assign pwrActive = (pwrMode == PWR_ACTIVE);
    assign csAvgCode = q.cfgA[CFGA_CSAVG_LSB +: 3];
    assign rtAvgCode = q.cfgA[CFGA_RTAVG_LSB +: 3];
    assign cutoffOn = q.cfgB[CFGB_CUTOFF_BIT];
    assign rtPeriod = 32'(rt_update_ms(rtAvgCode)) * 32'(MsCycles);

    // Debounce targets per alarm source
    assign debTarget[0] = chan_debounce(q.cfgB[CFGB_CHDEB_LSB +: 3]);
    assign debTarget[1] = temp_debounce(q.cfgB[CFGB_LTDEB_LSB +: 2]);
    assign debTarget[2] = temp_debounce(q.cfgB[CFGB_RT2DEB_LSB +: 2]);
    assign debTarget[3] = temp_debounce(q.cfgB[CFGB_RT1DEB_LSB +: 2]);

    always_comb
    begin
        d = q;
        d.rdata = '0;
        d.rtTick = 1'b0;

        // Reserved bits are stored as written
        if (regWrite)
        begin
            case (regAddr)
                ADDR_POWER:
                begin
                    d.power = regWdata;
                end
                ADDR_CFGA:
                begin
                    d.cfgA = regWdata;
                end
                ADDR_CFGB:
                begin
                    d.cfgB = regWdata;
                end
                // Identification words are constants, so a write has nothing to land in
                ADDR_PART, ADDR_REV, ADDR_MAKER:
                begin
                    d.power = q.power;
                end
                default:
                begin
                    d.power = q.power;
                end
            endcase
        end

        // Unmapped addresses read as zero
        if (regRead)
        begin
            case (regAddr)
                ADDR_POWER:
                begin
                    d.rdata = q.power;
                end
                ADDR_PART:
                begin
                    d.rdata = PartCode;
                end
                ADDR_REV:
                begin
                    d.rdata = RevisionCode;
                end
                ADDR_MAKER:
                begin
                    d.rdata = MakerCode;
                end
                ADDR_CFGA:
                begin
                    d.rdata = q.cfgA;
                end
                ADDR_CFGB:
                begin
                    d.rdata = q.cfgB;
                end
                default:
                begin
                    d.rdata = '0;
                end
            endcase
        end

        // Remote sensor update timer; stops while powered down or code invalid
        if (!pwrActive || rtPeriod == 32'h0)
        begin
            d.rtCnt = '0;
        end
        else if (q.rtCnt >= rtPeriod - 32'h1)
        begin
            d.rtCnt = '0;
            d.rtTick = 1'b1;
        end
        else
        begin
            d.rtCnt = q.rtCnt + 32'h1;
        end

        // Amplifier enable; a lockout is left only when the supply alarm is gone
        case (q.amp)
            AMP_OFF:
            begin
                if (ampOnReq && !(cutoffOn && negSupplyAlarm))
                begin
                    d.amp = AMP_ON;
                end
            end
            AMP_ON:
            begin
                if (cutoffOn && negSupplyAlarm)
                begin
                    d.amp = AMP_LOCKED;
                end
                else if (!ampOnReq)
                begin
                    d.amp = AMP_OFF;
                end
            end
            AMP_LOCKED:
            begin
                if (!negSupplyAlarm)
                begin
                    d.amp = AMP_OFF;
                end
            end
            default: d.amp = AMP_OFF;
        endcase

        // Result pin: high impedance unless enabled, function picked by bit 14
        d.pinOe = q.cfgB[CFGB_PINON_BIT];
        d.pinOut = q.cfgB[CFGB_PINFUNC_BIT] ? adcReadyIn : dataValidIn;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q.power <= RST_POWER;
            q.cfgA <= RST_CFGA;
            q.cfgB <= RST_CFGB;
            q.rdata <= '0;
            q.rtCnt <= '0;
            q.rtTick <= 1'b0;
            q.amp <= AMP_OFF;
            q.pinOut <= 1'b0;
            q.pinOe <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    // Alarm debouncers, one per source
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_deb
            mcr_debounce #(
                .CntW(9)
            ) u_deb (
                .clk(clk),
                .resetn(resetn),
                .sampleStb(alarmSampleStb[i]),
                .outOfRange(alarmOutOfRange[i]),
                .target(debTarget[i]),
                .alarm(alarmFlags[i])
            );
        end
    endgenerate

    // Filter only runs while the current sensors are powered
    mcr_cs_filter #(
        .SampleW(SampleW),
        .FracW(4)
    ) u_csf (
        .clk(clk),
        .resetn(resetn),
        .enable(pwrActive),
        .shift(csAvgCode),
        .sampleStb(csSampleStb),
        .sample(csSample),
        .filtered(csFiltered),
        .filteredValid(csFilteredValid)
    );

    // Power gating: upper bit low keeps only reference and bipolar DACs
    assign referenceOn = 1'b1;
    assign bipolarDacOn = 1'b1;
    assign currentSenseOn = pwrActive;
    assign adcOn = pwrActive;
    assign adcRefBufOn = pwrActive;
    assign dacRefBufOn = pwrActive;
    assign auxDacOn = pwrActive;
    // Factory code is flagged and treated as powered down
    assign powerCodeInvalid = (pwrMode == PWR_RSVD);

    assign conversionTriggerSel = q.cfgA[CFGA_TRIG_BIT];
    assign loopEnable = q.cfgA[CFGA_LOOP_BIT];
    assign remoteTempAvgSel = rtAvgCode;
    assign remoteDiodePnpSel = q.cfgB[CFGB_PNP_BIT];
    assign csAvgInvalid = (csAvgCode > CS_AVG_MAX);
    assign rtAvgInvalid = (rtAvgCode > RT_AVG_MAX);
    assign remoteTempTick = q.rtTick;

    assign regRdata = q.rdata;
    assign ampEnablePin = (q.amp == AMP_ON);
    assign resultPinOut = q.pinOut;
    assign resultPinOe = q.pinOe;
endmodule // mcr_regs

// ===== dv/mcr_regs_asserts.sv
// Port-level assertions for the monitor configuration register bank
`timescale 1ns/10ps
module mcr_regs_asserts
    import mcr_pkg::*;
#(
    parameter logic [DATA_W-1:0] PartCode = 16'h0000,
    parameter logic [DATA_W-1:0] RevisionCode = 16'h0000,
    parameter logic [DATA_W-1:0] MakerCode = 16'h0000
) (
    // Clock, reset and register port
    input wire logic clk,
    input wire logic resetn,
    input wire logic [mcr_pkg::ADDR_W-1:0] regAddr,
    input wire logic [mcr_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [mcr_pkg::DATA_W-1:0] regRdata,
    // Power enables
    input wire logic referenceOn,
    input wire logic currentSenseOn,
    input wire logic adcOn,
    input wire logic adcRefBufOn,
    input wire logic dacRefBufOn,
    input wire logic auxDacOn,
    input wire logic bipolarDacOn,
    // Configuration and amplifier
    input wire logic conversionTriggerSel,
    input wire logic loopEnable,
    input wire logic [2:0] remoteTempAvgSel,
    input wire logic ampOnReq,
    input wire logic ampEnablePin
);
    wire allOn = currentSenseOn & adcOn & adcRefBufOn & dacRefBufOn & auxDacOn;
    wire anyOn = currentSenseOn | adcOn | adcRefBufOn | dacRefBufOn | auxDacOn;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence rd_s(a);
        regRead && regAddr == a;
    endsequence
    sequence wr_s(a);
        regWrite && regAddr == a;
    endsequence

    // Write then read a little later must return the written word
    property cfg_rb_p;
        logic [15:0] d;
        (wr_s(ADDR_CFGA), d = regWdata) ##[1:2] rd_s(ADDR_CFGA) |=> regRdata == d;
    endproperty
    property cfg_out_p;
        logic [15:0] d;
        (wr_s(ADDR_CFGA), d = regWdata) |=>
            conversionTriggerSel == d[12] && loopEnable == d[0] && remoteTempAvgSel == d[6:4];
    endproperty

    part_id_a: assert property (rd_s(ADDR_PART) |=> regRdata == PartCode) else $error("part word wrong");
    rev_id_a: assert property (rd_s(ADDR_REV) |=> regRdata == RevisionCode) else $error("rev word wrong");
    maker_id_a: assert property (rd_s(ADDR_MAKER) |=> regRdata == MakerCode) else $error("maker wrong");
    cfg_readback_a: assert property (cfg_rb_p) else $error("config readback wrong");
    cfg_fields_a: assert property (cfg_out_p) else $error("config outputs wrong");
    power_active_a: assert property (regWrite && regAddr == ADDR_POWER && regWdata[1:0] == 2'h2 |=> allOn)
        else $error("active mode not powered");
    power_down_a: assert property (regWrite && regAddr == ADDR_POWER && !regWdata[1] |=>
        !anyOn && referenceOn && bipolarDacOn) else $error("power down wrong");
    power_group_a: assert property (anyOn |-> allOn) else $error("power enables split");
    amp_cause_a: assert property ($rose(ampEnablePin) |-> $past(ampOnReq)) else $error("amp on unasked");
endmodule // mcr_regs_asserts

// ===== dv/tb_mcr_regs.sv
// Self-checking bench for the monitor configuration register bank
`timescale 1ns/10ps
module tb_mcr_regs;
    import mcr_pkg::*;
    localparam int Ms = 4;
    localparam logic [15:0] Part = 16'h5A01; // Arbitrary value
    localparam logic [15:0] Rev = 16'h0A0A; // Arbitrary value
    localparam logic [15:0] Maker = 16'h0E0E; // Arbitrary value
    localparam logic [7:0] RA [7] = '{ADDR_POWER, ADDR_PART, ADDR_REV, ADDR_MAKER, ADDR_CFGA, ADDR_CFGB, 8'h20};
    localparam logic [15:0] RV [7] = '{16'h0000, Part, Rev, Maker, 16'h0300, 16'h036A, 16'h0000};
    localparam int TP [6] = '{16, 16, 18, 26, 50, 98};
    localparam int DC [8] = '{1, 4, 8, 16, 32, 64, 128, 256};
    logic clk = 0, resetn = 0, regWrite = 0, regRead = 0, csSampleStb = 0;
    logic ampOnReq = 0, negSupplyAlarm = 0, dataValidIn = 0, adcReadyIn = 0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000, regRdata;
    logic [11:0] csSample = 12'h000, csFiltered;
    logic [3:0] alarmSampleStb = 4'h0, alarmOutOfRange = 4'h0, alarmFlags;
    logic [2:0] remoteTempAvgSel;
    logic referenceOn, currentSenseOn, adcOn, adcRefBufOn, dacRefBufOn, auxDacOn, bipolarDacOn;
    logic conversionTriggerSel, loopEnable, csAvgInvalid, rtAvgInvalid, remoteTempTick, csFilteredValid;
    logic ampEnablePin, resultPinOut, resultPinOe, powerCodeInvalid, remoteDiodePnpSel;
    int nFail = 0, numChecks = 0;
    wire [4:0] pwrOn = {currentSenseOn, adcOn, adcRefBufOn, dacRefBufOn, auxDacOn};

    mcr_regs #(.PartCode(Part), .RevisionCode(Rev), .MakerCode(Maker), .MsCycles(Ms)) mcr_regs_i (.clk, .resetn,
        .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .referenceOn, .currentSenseOn, .adcOn, .adcRefBufOn,
        .dacRefBufOn, .auxDacOn, .bipolarDacOn, .powerCodeInvalid, .conversionTriggerSel, .loopEnable,
        .remoteTempAvgSel, .remoteDiodePnpSel, .csAvgInvalid, .rtAvgInvalid, .remoteTempTick, .csSampleStb,
        .csSample, .csFiltered, .csFilteredValid, .alarmSampleStb, .alarmOutOfRange, .alarmFlags, .ampOnReq,
        .negSupplyAlarm, .ampEnablePin, .dataValidIn, .adcReadyIn, .resultPinOut, .resultPinOe);

    initial
    begin
        forever #2 clk = ~clk;
    end

    task automatic giveVerdict();
        $display("Checks %0d, mismatches %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            nFail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'h1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        regRead <= 1'h1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'h0;
        #1;
        chk("regRdata", regRdata, exp);
    endtask

    task automatic wait_chk(input int c, input string nm, input logic [15:0] seen_now, input logic [15:0] exp);
        repeat (c) @(posedge clk);
        #1;
        case (nm)
            "amp": chk(nm, 16'(ampEnablePin), exp);
            default: chk(nm, 16'({resultPinOe, resultPinOut}), exp);
        endcase
    endtask

    // Edges between two ticks; a missing tick ends the run
    task automatic wait_tick(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (remoteTempTick !== 1'h1 && n < 2000);
        if (n >= 2000)
        begin
            nFail++;
            giveVerdict();
        end
    endtask

    task automatic cs_put(input logic [11:0] s, input logic [11:0] e);
        @(posedge clk);
        csSampleStb <= 1'h1;
        csSample <= s;
        @(posedge clk);
        csSampleStb <= 1'h0;
        #1;
        chk("csValid", 16'(csFilteredValid), 16'h1);
        chk("csFiltered", 16'(csFiltered), 16'(e));
    endtask

    // N-1 strobes leave the flag low, the N-th sets it, one in-range strobe clears it
    task automatic deb(input logic [3:0] m, input int n);
        @(posedge clk);
        alarmSampleStb <= m;
        alarmOutOfRange <= 4'hF;
        repeat (n - 1) @(posedge clk);
        #1;
        chk("flagsEarly", 16'(alarmFlags & m), 16'h0);
        @(posedge clk);
        alarmSampleStb <= 4'h0;
        #1;
        chk("flagsSet", 16'(alarmFlags & m), 16'(m));
        @(posedge clk);
        alarmSampleStb <= m;
        alarmOutOfRange <= 4'h0;
        @(posedge clk);
        alarmSampleStb <= 4'h0;
        @(posedge clk);
        #1;
        chk("flagsClr", 16'(alarmFlags & m), 16'h0);
    endtask

    initial
    begin
        int n;
        repeat (3) @(posedge clk);
        resetn <= 1'h1;
        #1;
        chk("pwrOn", 16'(pwrOn), 16'h0);
        chk("refOn", 16'({referenceOn, bipolarDacOn}), 16'h3);
        foreach (RA[i]) rd(RA[i], RV[i]);
        for (int i = 1; i < 4; i++)
        begin
            wr(RA[i], 16'hFFFF);
            rd(RA[i], RV[i]);
        end
        $display("Test reset and identity done");
        // Power code 11 is never written
        wr(ADDR_POWER, 16'h0002);
        #1;
        chk("pwrOn", 16'(pwrOn), 16'h1F);
        chk("pwrCodeBad", 16'(powerCodeInvalid), 16'h0);
        rd(ADDR_POWER, 16'h0002);
        wr(ADDR_POWER, 16'h0001);
        #1;
        chk("pwrOn", 16'(pwrOn), 16'h0);
        chk("refOn", 16'({referenceOn, bipolarDacOn}), 16'h3);
        $display("Test power modes done");
        wr(ADDR_CFGA, 16'hFFFF);
        rd(ADDR_CFGA, 16'hFFFF);
        wr(ADDR_CFGA, 16'h1051);
        #1;
        chk("cfgOut", 16'({conversionTriggerSel, loopEnable, remoteTempAvgSel, csAvgInvalid, rtAvgInvalid}),
            16'h74);
        wr(ADDR_CFGA, 16'h0460);
        #1;
        chk("cfgOut", 16'({conversionTriggerSel, loopEnable, remoteTempAvgSel, csAvgInvalid, rtAvgInvalid}),
            16'h19);
        wr(ADDR_CFGA, 16'h0500);
        #1;
        chk("csAvgInvalid", 16'(csAvgInvalid), 16'h1);
        $display("Test configuration fields done");
        wr(ADDR_POWER, 16'h0002);
        for (int c = 0; c < 6; c++)
        begin
            wr(ADDR_CFGA, 16'(c << 4));
            wait_tick(n);
            wait_tick(n);
            chk("tickGap", 16'(n), 16'(TP[c] * Ms));
        end
        wr(ADDR_CFGA, 16'h0000);
        cs_put(12'h100, 12'h100);
        wr(ADDR_CFGA, 16'h0100);
        cs_put(12'h200, 12'h180);
        $display("Test update timing and filter done");
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_CFGB, 16'((c << 8) | ((c & 3) * 16'h15)));
            deb(4'h1, DC[c]);
            deb(4'hE, 1 << (c & 3));
        end
        $display("Test alarm debounce done");
        wr(ADDR_CFGB, 16'h0040);
        ampOnReq <= 1'h1;
        wait_chk(2, "amp", 16'h0, 16'h1);
        negSupplyAlarm <= 1'h1;
        wait_chk(2, "amp", 16'h0, 16'h0);
        wait_chk(4, "amp", 16'h0, 16'h0);
        negSupplyAlarm <= 1'h0;
        wait_chk(3, "amp", 16'h0, 16'h1);
        wr(ADDR_CFGB, 16'h0000);
        negSupplyAlarm <= 1'h1;
        wait_chk(3, "amp", 16'h0, 16'h1);
        negSupplyAlarm <= 1'h0;
        wr(ADDR_CFGB, 16'h8080);
        dataValidIn <= 1'h1;
        wait_chk(2, "pin", 16'h0, 16'h3);
        chk("pnpSel", 16'(remoteDiodePnpSel), 16'h1);
        wr(ADDR_CFGB, 16'hC000);
        wait_chk(2, "pin", 16'h0, 16'h2);
        chk("pnpSel", 16'(remoteDiodePnpSel), 16'h0);
        $display("Test amplifier and result pin done");
        giveVerdict();
    end
endmodule // tb_mcr_regs

bind mcr_regs mcr_regs_asserts #(.PartCode(PartCode), .RevisionCode(RevisionCode), .MakerCode(MakerCode))
    mcr_regs_asserts_i (.clk, .resetn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .referenceOn,
    .currentSenseOn, .adcOn, .adcRefBufOn, .dacRefBufOn, .auxDacOn, .bipolarDacOn, .conversionTriggerSel,
    .loopEnable, .remoteTempAvgSel, .ampOnReq, .ampEnablePin);
